// File: ddo_decim_out.sv
// Decimation chain, output word formatter, two-word buffer and AHB-Lite regs
//
// The register offsets and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/100ps

module ddo_decim_out
  import ddo_pkg::*;
(
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  input wire logic SAMPLE_VALID_I,
  output logic SAMPLE_READY_O,
  input wire logic [11:0] SAMPLE_RE_I,
  input wire logic [11:0] SAMPLE_IM_I,
  input wire logic OVERRANGE_THRESH_FLAG0_I,
  input wire logic OVERRANGE_THRESH_FLAG1_I,
  output logic WORD_VALID_O,
  input wire logic WORD_READY_I,
  output logic [15:0] WORD_O,
  output logic CHAN_A_OVERRANGE_PIN0_O,
  output logic CHAN_A_OVERRANGE_PIN1_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Register bus
  ddo_ctrl_t ctrl;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic clr;
  logic [15:0] word_count;
  logic bus_take;
  logic [31:0] status;
  ddo_fmt_t fmt;
  logic h_v;
  logic t_v;

  assign bus_take = HSEL_I && HTRANS_I[1] && HREADY_I;
  assign status = {word_count, 12'h000, fmt == FMT_QWORD, SAMPLE_READY_O,
                   t_v, h_v};

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= bus_take && HWRITE_I;
      wr_addr <= HADDR_I[7:0];
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      ctrl <= '{boost: 1'b0, wide: 1'b0, mode: MODE_BYPASS};
      clr <= 1'b0;
    end else begin
      clr <= 1'b0;
      if (wr_pend && wr_addr == ADDR_CTRL) begin
        ctrl.mode <= HWDATA_I[CTRL_MODE_LSB +: 5];
        ctrl.wide <= HWDATA_I[CTRL_WIDE_BIT];
        ctrl.boost <= HWDATA_I[CTRL_BOOST_BIT];
        clr <= 1'b1;
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      HRDATA_O <= BUS_ZERO;
      HREADYOUT_O <= 1'b1;
      HRESP_O <= 1'b0;
    end else begin
      HREADYOUT_O <= 1'b1;
      HRESP_O <= 1'b0;
      HRDATA_O <= BUS_ZERO;
      if (bus_take && !HWRITE_I) begin
        if (HADDR_I[7:0] == ADDR_CTRL)
          HRDATA_O <= {22'h00_0000, ctrl.boost, ctrl.wide, 3'h0, ctrl.mode};
        else if (HADDR_I[7:0] == ADDR_STATUS)
          HRDATA_O <= status;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode
  logic is_d2;
  logic is_d4;
  logic is_d8;
  logic is_d16;
  logic is_byp;
  logic is_narrow;
  logic is_cplx;

  always_comb begin
    is_d2 = ctrl.mode == MODE_D2;
    is_d4 = ctrl.mode >= MODE_D4_LO && ctrl.mode < MODE_D8_LO;
    is_d8 = ctrl.mode >= MODE_D8_LO && ctrl.mode < MODE_D16_LO;
    is_d16 = ctrl.mode >= MODE_D16_LO && ctrl.mode <= MODE_D16_HI;
    is_byp = !(is_d2 || is_d4 || is_d8 || is_d16);
    is_narrow = ctrl.mode == MODE_D4_NARROW;
    is_cplx = is_d4 || is_d8 || is_d16;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stage cascade
  logic acc_in;
  ddo_cplx_t in_s;
  logic v_in10, v_in20, v_in40, v_in45, v_in80, v_in87;
  logic v10, v20, v40, v45, v80, v87;
  ddo_cplx_t d10, d20, d40, d45, d80, d87;
  ddo_cplx_t i20, i80;
  logic fin_v;
  ddo_cplx_t fin_d;

  assign acc_in = SAMPLE_VALID_I && SAMPLE_READY_O;

  always_comb begin
    // Real path drops the imaginary rail
    in_s.re = {SAMPLE_RE_I, 4'h0};
    in_s.im = is_cplx ? {SAMPLE_IM_I, 4'h0} : 16'h0000;
    // Order of stages per setting
    v_in10 = acc_in && is_d16;
    v_in20 = is_d16 ? v10 : (acc_in && is_d8);
    i20 = is_d16 ? d10 : in_s;
    v_in40 = v20 && (is_d8 || is_d16);
    v_in45 = acc_in && is_d4;
    v_in80 = is_d2 ? acc_in : (is_d4 ? (v45 && !ctrl.wide) : v40);
    i80 = is_d2 ? in_s : (is_d4 ? d45 : d40);
    v_in87 = v45 && ctrl.wide;
    if (is_byp) begin
      fin_v = acc_in;
      fin_d = in_s;
    end else if (is_d4 && ctrl.wide) begin
      fin_v = v87;
      fin_d = d87;
    end else begin
      fin_v = v80;
      fin_d = d80;
    end
  end

  ddo_hb_stage #(.SEL(ST_TEN)) u_ten (
    .clk_i(MCLK_I), .rst_i(RST_I), .clr_i(clr), .boost_i(1'b0),
    .in_valid_i(v_in10), .in_i(in_s), .out_valid_o(v10), .out_o(d10));
  ddo_hb_stage #(.SEL(ST_TWENTY)) u_twenty (
    .clk_i(MCLK_I), .rst_i(RST_I), .clr_i(clr), .boost_i(1'b0),
    .in_valid_i(v_in20), .in_i(i20), .out_valid_o(v20), .out_o(d20));
  ddo_hb_stage #(.SEL(ST_FORTY)) u_forty (
    .clk_i(MCLK_I), .rst_i(RST_I), .clr_i(clr), .boost_i(1'b0),
    .in_valid_i(v_in40), .in_i(d20), .out_valid_o(v40), .out_o(d40));
  ddo_hb_stage #(.SEL(ST_FORTYFIVE)) u_fortyfive (
    .clk_i(MCLK_I), .rst_i(RST_I), .clr_i(clr), .boost_i(1'b0),
    .in_valid_i(v_in45), .in_i(in_s), .out_valid_o(v45), .out_o(d45));
  // Boost lives in whichever stage ends the chain
  ddo_hb_stage #(.SEL(ST_EIGHTY)) u_eighty (
    .clk_i(MCLK_I), .rst_i(RST_I), .clr_i(clr), .boost_i(ctrl.boost),
    .in_valid_i(v_in80), .in_i(i80), .out_valid_o(v80), .out_o(d80));
  ddo_hb_stage #(.SEL(ST_WIDE)) u_wide (
    .clk_i(MCLK_I), .rst_i(RST_I), .clr_i(clr), .boost_i(ctrl.boost),
    .in_valid_i(v_in87), .in_i(d45), .out_valid_o(v87), .out_o(d87));

  ////////////////////////////////////////////////////////////////////////////
  // Output word formatter
  logic flag0_acc;
  logic flag1_acc;
  logic flag0;
  logic flag1;
  logic odd;
  logic [15:0] q_word;
  logic push;
  logic [15:0] push_word;
  logic space;
  logic pop;

  assign flag0 = flag0_acc || OVERRANGE_THRESH_FLAG0_I;
  assign flag1 = flag1_acc || OVERRANGE_THRESH_FLAG1_I;
  assign pop = h_v && WORD_READY_I;
  assign space = !h_v || !t_v || pop;

  always_comb begin
    push = 1'b0;
    push_word = 16'h0000;
    if (fmt == FMT_QWORD) begin
      push = space;
      push_word = q_word;
    end else if (fin_v) begin
      push = 1'b1;
      if (is_byp || is_narrow)
        push_word = {fin_d.re[DW-1 -: NARROW], 4'h0};
      else if (is_d2)
        push_word = {fin_d.re[DW-1 -: OW], odd ? flag1 : flag0};
      else
        push_word = {fin_d.re[DW-1 -: OW], flag0};
    end
  end

  // Flags are gathered over each output sample period
  always_ff @(posedge MCLK_I) begin
    if (RST_I || clr) begin
      flag0_acc <= 1'b0;
      flag1_acc <= 1'b0;
    end else if (fin_v) begin
      flag0_acc <= 1'b0;
      flag1_acc <= 1'b0;
    end else if (acc_in) begin
      flag0_acc <= flag0;
      flag1_acc <= flag1;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I || clr) begin
      fmt <= FMT_IWORD;
      odd <= 1'b0;
      q_word <= 16'h0000;
    end else begin
      unique case (fmt)
        FMT_IWORD: begin
          if (fin_v && is_d2) odd <= ~odd;
          if (fin_v && is_cplx) begin
            fmt <= FMT_QWORD;
            if (is_narrow)
              q_word <= {fin_d.im[DW-1 -: NARROW], 4'h0};
            else
              q_word <= {fin_d.im[DW-1 -: OW], flag1};
          end
        end
        FMT_QWORD: begin
          if (space) fmt <= FMT_IWORD;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-word output buffer
  logic next_h_v;
  logic next_t_v;
  logic [15:0] next_h;
  logic [15:0] next_t;
  logic [15:0] t_word;

  always_comb begin
    next_h_v = h_v;
    next_t_v = t_v;
    next_h = WORD_O;
    next_t = t_word;
    if (pop || !h_v) begin
      if (t_v) begin
        next_h = t_word;
        next_h_v = 1'b1;
        next_t_v = push;
        next_t = push_word;
      end else begin
        next_h_v = push;
        next_h = push_word;
      end
    end else if (push) begin
      next_t_v = 1'b1;
      next_t = push_word;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      h_v <= 1'b0;
      t_v <= 1'b0;
      WORD_O <= 16'h0000;
      t_word <= 16'h0000;
      SAMPLE_READY_O <= 1'b0;
    end else begin
      h_v <= next_h_v;
      t_v <= next_t_v;
      WORD_O <= next_h;
      t_word <= next_t;
      SAMPLE_READY_O <= !(next_h_v && next_t_v) &&
                        !(fmt == FMT_IWORD && fin_v && is_cplx) &&
                        !(fmt == FMT_QWORD && !space);
    end
  end

  assign WORD_VALID_O = h_v;

  always_ff @(posedge MCLK_I) begin
    if (RST_I) word_count <= 16'h0000;
    else if (pop) word_count <= word_count + 16'h0001;
  end

  // Overrange pins follow the detector in every mode
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      CHAN_A_OVERRANGE_PIN0_O <= 1'b0;
      CHAN_A_OVERRANGE_PIN1_O <= 1'b0;
    end else begin
      CHAN_A_OVERRANGE_PIN0_O <= OVERRANGE_THRESH_FLAG0_I;
      CHAN_A_OVERRANGE_PIN1_O <= OVERRANGE_THRESH_FLAG1_I;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  a_real_flag_parity: assert property (@(posedge MCLK_I) disable iff (RST_I)
    push && is_d2 && fmt == FMT_IWORD |->
      push_word[0] == (odd ? flag1 : flag0))
    else $error("real word carries wrong flag");

  a_iq_word_pair: assert property (@(posedge MCLK_I) disable iff (RST_I)
    fin_v && is_cplx && fmt == FMT_IWORD && !clr |=>
      fmt == FMT_QWORD && !SAMPLE_READY_O)
    else $error("quadrature word not queued after in-phase word");

  a_narrow_no_flags: assert property (@(posedge MCLK_I) disable iff (RST_I)
    push && is_narrow |-> push_word[NARROW_PAD-1:0] == 4'h0)
    else $error("mode 12 word carries flag bits");

  a_full_stalls: assert property (@(posedge MCLK_I) disable iff (RST_I)
    h_v && t_v |-> !SAMPLE_READY_O)
    else $error("input ready while buffer is full");

  a_bypass_rate: assert property (@(posedge MCLK_I) disable iff (RST_I)
    acc_in && is_byp |-> push && push_word[NARROW_PAD-1:0] == 4'h0)
    else $error("bypass sample not emitted at once");

  a_quarter_path: assert property (@(posedge MCLK_I) disable iff (RST_I)
    fin_v && is_d4 |-> v45 && !v40 && !v10)
    else $error("decimate by four used wrong stages");

  a_eighth_path: assert property (@(posedge MCLK_I) disable iff (RST_I)
    fin_v && is_d8 |-> v20 && v40 && !v10 && !v45)
    else $error("decimate by eight used wrong stages");

  a_sixteenth_path: assert property (@(posedge MCLK_I) disable iff (RST_I)
    fin_v && is_d16 |-> v10 && v20 && v40 && acc_in)
    else $error("decimate by sixteen used wrong stages");

  a_pin_follow: assert property (@(posedge MCLK_I) disable iff (RST_I)
    ##1 CHAN_A_OVERRANGE_PIN1_O == $past(OVERRANGE_THRESH_FLAG1_I))
    else $error("overrange pin does not follow flag");

  a_word_holds: assert property (@(posedge MCLK_I) disable iff (RST_I)
    WORD_VALID_O && !WORD_READY_I |=> WORD_VALID_O && $stable(WORD_O))
    else $error("stalled output word changed");
endmodule : ddo_decim_out

// File: ddo_hb_stage.sv
// Package and half-band decimate-by-two stage of the decimation chain
`timescale 1ns/100ps

package ddo_pkg;
  localparam int DW = 16;
  localparam int OW = 15;
  localparam int IW = 12;
  localparam int NARROW = 12;
  localparam int MAX_SIDES = 16;
  // Stage identifiers
  localparam int ST_TEN = 0;
  localparam int ST_TWENTY = 1;
  localparam int ST_FORTY = 2;
  localparam int ST_FORTYFIVE = 3;
  localparam int ST_EIGHTY = 4;
  localparam int ST_WIDE = 5;
  // Transport modes
  localparam logic [4:0] MODE_BYPASS = 5'h00;
  localparam logic [4:0] MODE_D2 = 5'h09;
  localparam logic [4:0] MODE_D4_LO = 5'h0A;
  localparam logic [4:0] MODE_D4_NARROW = 5'h0C;
  localparam logic [4:0] MODE_D8_LO = 5'h0D;
  localparam logic [4:0] MODE_D16_LO = 5'h0F;
  localparam logic [4:0] MODE_D16_HI = 5'h10;
  // Register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_WIDE_BIT = 8;
  localparam int CTRL_BOOST_BIT = 9;
  localparam logic [31:0] BUS_ZERO = 32'h0000_0000;
  localparam int NARROW_PAD = DW - NARROW;

  typedef struct packed {
    logic signed [DW-1:0] re;
    logic signed [DW-1:0] im;
  } ddo_cplx_t;

  typedef struct packed {
    logic boost;
    logic wide;
    logic [4:0] mode;
  } ddo_ctrl_t;

  typedef enum logic [0:0] {FMT_IWORD = 1'b0, FMT_QWORD = 1'b1} ddo_fmt_t;

  localparam int CF_TEN[2] = '{-65, 577};
  localparam int CF_TWENTY[3] = '{109, -837, 4824};
  localparam int CF_FORTY[4] = '{-327, 2231, -8881, 39742};
  localparam int CF_FORTYFIVE[5] = '{56, -401, 1596, -4979, 20113};
  localparam int CF_EIGHTY[14] = '{-37, 118, -291, 612, -1159, 2031,
    -3356, 5308, -8140, 12284, -18628, 29455, -53191, 166059};
  localparam int CF_WIDE[16] = '{-15, 23, -40, 64, -97, 142, -201, 279,
    -380, 513, -690, 939, -1313, 1956, -3398, 10404};
  localparam int CENTER[6] = '{1024, 8192, 65536, 32768, 262144, 16384};
  // Unity gain shift: log2 of twice the center tap
  localparam int GAIN_SHIFT[6] = '{11, 14, 17, 16, 19, 15};
  localparam int SIDES[6] = '{2, 3, 4, 5, 14, 16};

  function automatic int ddo_coef(input int sel, input int k);
    case (sel)
      ST_TEN: ddo_coef = (k < 2) ? CF_TEN[k] : 0;
      ST_TWENTY: ddo_coef = (k < 3) ? CF_TWENTY[k] : 0;
      ST_FORTY: ddo_coef = (k < 4) ? CF_FORTY[k] : 0;
      ST_FORTYFIVE: ddo_coef = (k < 5) ? CF_FORTYFIVE[k] : 0;
      ST_EIGHTY: ddo_coef = (k < 14) ? CF_EIGHTY[k] : 0;
      default: ddo_coef = CF_WIDE[k];
    endcase
  endfunction : ddo_coef
endpackage : ddo_pkg

module ddo_hb_stage
  import ddo_pkg::*;
#(
  parameter int SEL = ST_EIGHTY
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clr_i,
  input wire logic boost_i,
  input wire logic in_valid_i,
  input wire ddo_cplx_t in_i,
  output logic out_valid_o,
  output ddo_cplx_t out_o
);
  localparam int NS = SIDES[SEL];
  localparam int NT = 4 * NS - 1;
  localparam int MID = 2 * NS - 1;
  localparam longint SAT_HI = 32767;
  localparam longint SAT_LO = -32768;

  ddo_cplx_t hist [NT-1];
  ddo_cplx_t win [NT];
  logic phase;
  longint acc_re;
  longint acc_im;
  longint sc_re;
  longint sc_im;
  int sh;

  always_ff @(posedge clk_i) begin
    if (rst_i || clr_i) begin
      phase <= 1'b0;
      for (int j = 0; j < NT - 1; j++) hist[j] <= '0;
    end else if (in_valid_i) begin
      phase <= ~phase;
      hist[0] <= in_i;
      for (int j = 1; j < NT - 1; j++) hist[j] <= hist[j-1];
    end
  end

  always_comb begin
    win[0] = in_i;
    for (int j = 1; j < NT; j++) win[j] = hist[j-1];
  end

  // Every second accepted input yields one output
  assign out_valid_o = in_valid_i && phase;

  // Symmetric taps, odd taps zero, single center tap
  always_comb begin
    acc_re = longint'(CENTER[SEL]) * longint'(win[MID].re);
    acc_im = longint'(CENTER[SEL]) * longint'(win[MID].im);
    for (int k = 0; k < NS; k++) begin
      acc_re = acc_re + longint'(ddo_coef(SEL, k)) *
        (longint'(win[2*k].re) + longint'(win[NT-1-2*k].re));
      acc_im = acc_im + longint'(ddo_coef(SEL, k)) *
        (longint'(win[2*k].im) + longint'(win[NT-1-2*k].im));
    end
    sh = GAIN_SHIFT[SEL] - (boost_i ? 1 : 0);
    sc_re = acc_re >>> sh;
    sc_im = acc_im >>> sh;
    if (sc_re > SAT_HI) sc_re = SAT_HI;
    if (sc_re < SAT_LO) sc_re = SAT_LO;
    if (sc_im > SAT_HI) sc_im = SAT_HI;
    if (sc_im < SAT_LO) sc_im = SAT_LO;
    out_o.re = sc_re[DW-1:0];
    out_o.im = sc_im[DW-1:0];
  end

  a_halving_pace: assert property (@(posedge clk_i) disable iff (rst_i)
    out_valid_o |-> !$past(out_valid_o) || clr_i || $past(clr_i))
    else $error("stage output twice without an input between");
endmodule : ddo_hb_stage

// File: ddo_word_sink.sv
// Far-side word receiver model with prompt, slow and held-off readiness
`timescale 1ns/100ps

module ddo_word_sink (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic stall_i,
  input wire logic hold_i,
  input wire logic word_valid_i,
  input wire logic [15:0] word_i,
  output logic word_ready_o
);
  logic [15:0] words[$];
  logic [1:0] phase;

  always @(posedge clk_i) begin
    if (rst_i) begin
      phase <= 2'h0;
      word_ready_o <= 1'b0;
    end else begin
      if (word_valid_i && word_ready_o) begin
        words.push_back(word_i);
      end
      phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
      // Slow mode refuses one cycle in three
      word_ready_o <= !hold_i && !(stall_i && phase == 2'h2);
    end
  end
endmodule : ddo_word_sink

// File: ddo_decim_out_tb_top.sv
// Self-checking bench for the decimation chain and output formatter
`timescale 1ns/100ps

module ddo_decim_out_tb_top import ddo_pkg::*;;
  logic mclk = 1'b0, rst = 1'b1, hsel = 1'b1, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic svalid = 1'b0, f0 = 1'b1, f1 = 1'b0, stall = 1'b0, hold = 1'b0;
  logic [11:0] sre = 12'h100, sim = 12'hF80;
  logic [31:0] hrdata;
  logic hreadyout, hresp, sready, wvalid, wready, pin0, pin1;
  logic [15:0] word;
  int fails = 0;
  int total_checks = 0;

  always #4 mclk = ~mclk;

  ddo_decim_out u_dut (
    .MCLK_I(mclk), .RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize),
    .HWDATA_I(hwdata), .HREADY_I(hreadyout), .HRDATA_O(hrdata),
    .HREADYOUT_O(hreadyout), .HRESP_O(hresp), .SAMPLE_VALID_I(svalid),
    .SAMPLE_READY_O(sready), .SAMPLE_RE_I(sre), .SAMPLE_IM_I(sim),
    .OVERRANGE_THRESH_FLAG0_I(f0), .OVERRANGE_THRESH_FLAG1_I(f1),
    .WORD_VALID_O(wvalid), .WORD_READY_I(wready), .WORD_O(word),
    .CHAN_A_OVERRANGE_PIN0_O(pin0), .CHAN_A_OVERRANGE_PIN1_O(pin1)
  );

  ddo_word_sink u_sink (
    .clk_i(mclk), .rst_i(rst), .stall_i(stall), .hold_i(hold),
    .word_valid_i(wvalid), .word_i(word), .word_ready_o(wready)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    if (fails == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out

  task automatic check(input string name, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  function automatic logic near(input logic signed [15:0] v, input int e);
    logic signed [31:0] d;
    d = v - e;
    return d <= 4 && d >= -4;
  endfunction : near

  function automatic int fac_of(input logic [4:0] m);
    case (m)
      5'h09: return 2;
      5'h0A, 5'h0B, 5'h0C: return 4;
      5'h0D, 5'h0E: return 8;
      5'h0F, 5'h10: return 16;
      default: return 1;
    endcase
  endfunction : fac_of

  ////////////////////////////////////////////////////////////////////////
  // Bus wait: values sampled just before the edge that ends the phase
  task automatic bus_wait(output logic [31:0] rd);
    logic rdy;
    for (int i = 0; i < 50; i++) begin
      @(negedge mclk);
      rdy = hreadyout;
      rd = hrdata;
      @(posedge mclk);
      if (rdy) return;
    end
    fails++;
    close_out();
  endtask : bus_wait

  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    bus_wait(rd);
    htrans <= 2'h0;
    hwdata <= wd;
    bus_wait(rd);
  endtask : ahb

  task automatic feed(input int n);
    int got;
    logic r;
    got = 0;
    svalid <= 1'b1;
    for (int i = 0; i < 20 * n && got < n; i++) begin
      @(negedge mclk);
      r = sready;
      @(posedge mclk);
      if (r) got++;
    end
    svalid <= 1'b0;
    if (got != n) begin
      fails++;
      close_out();
    end
  endtask : feed

  task automatic drain;
    int idle;
    idle = 0;
    for (int i = 0; i < 400 && idle < 4; i++) begin
      @(negedge mclk);
      idle = wvalid ? 0 : idle + 1;
      @(posedge mclk);
    end
    if (idle < 4) begin
      fails++;
      close_out();
    end
  endtask : drain

  ////////////////////////////////////////////////////////////////////////
  task automatic sc_regs;
    logic [31:0] rd;
    ahb(1'b0, ADDR_CTRL, 32'h0000_0000, rd);
    check("ctrl_rst", rd, 32'h0000_0000);
    ahb(1'b0, ADDR_STATUS, 32'h0000_0000, rd);
    check("status_rst", rd, 32'h0000_0004);
    ahb(1'b1, 8'h08, 32'hFFFF_FFFF, rd);
    ahb(1'b0, 8'h08, 32'h0000_0000, rd);
    check("unmapped", rd, 32'h0000_0000);
    ahb(1'b1, ADDR_CTRL, 32'h0000_030E, rd);
    ahb(1'b0, ADDR_CTRL, 32'h0000_0000, rd);
    check("ctrl_rw", rd, 32'h0000_030E);
    check("hresp", hresp, 1'b0);
    check("hready", hreadyout, 1'b1);
  endtask : sc_regs

  task automatic sc_mode(input logic [4:0] m, input logic wd,
                         input logic bst, input logic st);
    int fac, g, sz, cnt;
    logic cx;
    logic [31:0] rd;
    logic [15:0] wi, wq;
    fac = fac_of(m);
    g = bst ? 2 : 1;
    cx = fac > 2;
    cnt = (cx ? 3072 : 1536) / fac;
    stall <= st;
    f1 <= st;
    drain();
    ahb(1'b1, ADDR_CTRL, {22'h0, bst, wd, 3'h0, m}, rd);
    repeat (2) @(posedge mclk);
    u_sink.words.delete();
    feed(1536);
    drain();
    sz = u_sink.words.size();
    check("words", sz, cnt);
    wi = u_sink.words[sz - 2];
    wq = u_sink.words[sz - 1];
    if (fac == 1) begin
      check("bypass", wq, {sre, 4'h0});
    end else if (m == 5'h0C) begin
      check("n_i", near($signed(wi[15:4]), g * 256), 1'b1);
      check("n_q", near($signed(wq[15:4]), g * -128), 1'b1);
      check("n_pad", {wi[3:0], wq[3:0]}, 8'h00);
      check("n_pin", {pin0, pin1}, {f0, f1});
    end else begin
      check("d0", near($signed(wi[15:1]), g * 2048), 1'b1);
      check("d1", near($signed(wq[15:1]), g * (cx ? -1024 : 2048)),
            1'b1);
      check("flags", {wi[0], wq[0]}, {f0, f1});
    end
  endtask : sc_mode

  task automatic sc_fill;
    int got;
    logic r;
    logic [31:0] rd, c0;
    stall <= 1'b0;
    drain();
    ahb(1'b1, ADDR_CTRL, 32'h0000_0000, rd);
    ahb(1'b0, ADDR_STATUS, 32'h0000_0000, c0);
    u_sink.words.delete();
    hold <= 1'b1;
    sre <= 12'hED4;
    repeat (2) @(posedge mclk);
    got = 0;
    svalid <= 1'b1;
    repeat (8) begin
      @(negedge mclk);
      r = sready;
      @(posedge mclk);
      if (r) got++;
    end
    svalid <= 1'b0;
    check("fill_taken", got, 2);
    ahb(1'b0, ADDR_STATUS, 32'h0000_0000, rd);
    check("full_status", rd[3:0], 4'h3);
    hold <= 1'b0;
    drain();
    check("drained", u_sink.words.size(), 2);
    check("fill_word", u_sink.words[0], 16'hED40);
    ahb(1'b0, ADDR_STATUS, 32'h0000_0000, rd);
    check("empty_status", rd[1:0], 2'h0);
    check("pop_count", rd[31:16], c0[31:16] + 16'h0002);
  endtask : sc_fill

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    sc_regs();
    sc_mode(5'h00, 1'b0, 1'b0, 1'b0);
    sc_mode(5'h09, 1'b0, 1'b0, 1'b1);
    sc_mode(5'h0A, 1'b0, 1'b0, 1'b0);
    sc_mode(5'h0B, 1'b0, 1'b0, 1'b1);
    sc_mode(5'h0C, 1'b0, 1'b0, 1'b0);
    sc_mode(5'h0A, 1'b1, 1'b0, 1'b1);
    sc_mode(5'h0D, 1'b0, 1'b0, 1'b0);
    sc_mode(5'h0E, 1'b0, 1'b0, 1'b1);
    sc_mode(5'h0F, 1'b0, 1'b0, 1'b0);
    sc_mode(5'h10, 1'b0, 1'b0, 1'b1);
    // Boost only with a DC input the filters keep image-free
    sc_mode(5'h09, 1'b0, 1'b1, 1'b0);
    sc_mode(5'h0A, 1'b0, 1'b1, 1'b1);
    sc_mode(5'h1F, 1'b0, 1'b0, 1'b0);
    sc_fill();
    close_out();
  end
endmodule : ddo_decim_out_tb_top
